// ---- rtl/asc_transceiver.sv ----
`timescale 1ns/1ps
module asc_transceiver
  import asc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // configuration
  input wire asc_frame_cfg_type frame_cfg,
  input wire logic [7:0] baud_divisor,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_empty_irq_en,
  input wire logic rx_irq_en,
  input wire logic tx_done_irq_en,
  input wire logic id_marker_tx,
  // transmit data stream
  input wire logic tx_wr_valid,
  input wire logic [7:0] tx_wr_data,
  output logic tx_wr_ready,
  // status
  output logic tx_empty_flag,
  output logic tx_done_flag,
  output logic rx_full_flag,
  output asc_rx_fault_type rx_faults,
  output logic [7:0] rx_holding,
  output logic id_marker_bit,
  // software clears, one-cycle pulses
  input wire logic rx_full_clr,
  input wire asc_rx_fault_type rx_fault_clr,
  // interrupt requests, highest first
  output logic rx_fault_req,
  output logic rx_full_req,
  output logic tx_empty_req,
  output logic tx_done_req,
  // serial line
  input wire logic rxd_pin,
  output logic txd_pin
);

  function automatic logic odd_ones(input logic [7:0] d, input logic seven);
    odd_ones = ^(seven ? (d & SEVEN_BIT_MASK) : d);
  endfunction

  // hardware set wins over a same-cycle software clear
  function automatic logic sticky(input logic cur, input logic set_now, input logic clr_now);
    sticky = set_now | (cur & ~clr_now);
  endfunction

  // shared format decode
  wire tick16;
  wire [2:0] last_bit = frame_cfg.seven_bit_sel ? LAST_BIT_SEVEN : LAST_BIT_EIGHT;
  wire opt_on = frame_cfg.multiproc_format | frame_cfg.parity_on;

  asc_baud_gen u_baud (
    .sys_clk(sys_clk), .resetn(resetn), .baud_divisor(baud_divisor), .tick16(tick16),
    .prescale_sel({frame_cfg.prescale_sel_hi, frame_cfg.prescale_sel_lo})
  );

  // transmit
  asc_tx_state_type tx_state;
  logic [3:0] tx_cnt;
  logic [2:0] tx_idx;
  logic [7:0] tx_shifter;
  logic [7:0] tx_holding;
  logic tx_opt;
  logic tx_line;
  wire buf_valid;
  wire [7:0] buf_data;

  // handover from buffer is the write plus the clear of the empty flag
  wire drain = buf_valid & tx_enable & tx_empty_flag;

  asc_pair_buffer #(.WIDTH(TX_BUF_WIDTH), .DEPTH(TX_BUF_DEPTH)) u_txbuf (
    .sys_clk(sys_clk), .resetn(resetn),
    .in_valid(tx_wr_valid), .in_data(tx_wr_data), .in_ready(tx_wr_ready),
    .out_valid(buf_valid), .out_data(buf_data), .out_ready(drain)
  );

  wire tx_bit_end = tick16 & (tx_cnt == LAST_SLOT);
  wire tx_last_stop = (tx_idx != 3'h0) | ~frame_cfg.stop_two;
  wire tx_stop_end = (tx_state == TX_STOP) & tx_bit_end & tx_last_stop;
  wire tx_load = tx_enable & ~tx_empty_flag & ((tx_state == TX_IDLE) | tx_stop_end);
  wire tx_data_done = (tx_state == TX_DATA) & tx_bit_end & (tx_idx == last_bit);
  wire tx_stop_enter = (tx_data_done & ~opt_on) | ((tx_state == TX_OPT) & tx_bit_end);
  wire next_opt = frame_cfg.multiproc_format ? id_marker_tx
                : odd_ones(tx_holding, frame_cfg.seven_bit_sel) ^ frame_cfg.odd_parity_sel;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_holding <= 8'h00;
    end else if (drain) begin
      tx_holding <= buf_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 4'h0;
      tx_idx <= 3'h0;
      tx_shifter <= 8'h00;
      tx_opt <= 1'b0;
      tx_line <= 1'b1;
    end else if (!tx_enable) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 4'h0;
      tx_idx <= 3'h0;
      tx_shifter <= 8'h00;
      tx_line <= 1'b1;
    end else if (tx_load) begin
      tx_state <= TX_START;
      tx_cnt <= 4'h0;
      tx_idx <= 3'h0;
      tx_shifter <= tx_holding;
      tx_opt <= next_opt;
      tx_line <= 1'b0;
    end else begin
      if (tick16) begin
        tx_cnt <= tx_cnt + 4'h1;
      end
      case (tx_state)
        TX_IDLE: begin
          tx_line <= 1'b1;
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_state <= TX_DATA;
            tx_line <= tx_shifter[0];
          end
        end
        TX_DATA: begin
          if (tx_data_done) begin
            tx_state <= opt_on ? TX_OPT : TX_STOP;
            tx_line <= opt_on ? tx_opt : 1'b1;
            tx_idx <= 3'h0;
          end else if (tx_bit_end) begin
            tx_shifter <= {1'b0, tx_shifter[7:1]};
            tx_line <= tx_shifter[1];
            tx_idx <= tx_idx + 3'h1;
          end
        end
        TX_OPT: begin
          if (tx_bit_end) begin
            tx_state <= TX_STOP;
            tx_line <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_stop_end) begin
            tx_state <= TX_IDLE;
          end else if (tx_bit_end) begin
            tx_idx <= 3'h1;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
          tx_line <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
    end else begin
      tx_empty_flag <= sticky(tx_empty_flag, !tx_enable | tx_load, drain);
      tx_done_flag <= sticky(tx_done_flag, !tx_enable | (tx_stop_enter & tx_empty_flag), drain);
    end
  end

  assign txd_pin = tx_line;

  // receive
  logic rxd_meta;
  logic rxd_sync;
  logic rxd_prev;
  asc_rx_state_type rx_state;
  logic [3:0] rx_cnt;
  logic [2:0] rx_idx;
  logic [7:0] rx_shifter;
  logic rx_opt;

  wire any_fault = rx_faults.overrun_fault | rx_faults.frame_fault | rx_faults.parity_fault;
  wire start_seen = rx_enable & ~any_fault & rxd_prev & ~rxd_sync;
  wire rx_sample = tick16 & (rx_cnt == SAMPLE_POINT);
  wire rx_bit_end = tick16 & (rx_cnt == LAST_SLOT);
  wire rx_done = (rx_state == RX_STOP) & rx_sample;
  wire [7:0] rx_char = frame_cfg.seven_bit_sel ? {1'b0, rx_shifter[7:1]} : rx_shifter;
  wire par_bad = frame_cfg.parity_on & ~frame_cfg.multiproc_format
               & (odd_ones(rx_char, 1'b0) ^ rx_opt ^ frame_cfg.odd_parity_sel);
  wire stop_bad = ~rxd_sync;
  wire overrun = rx_done & rx_full_flag;
  wire rx_store = rx_done & ~rx_full_flag;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_prev <= 1'b1;
    end else begin
      rxd_meta <= rxd_pin;
      rxd_sync <= rxd_meta;
      rxd_prev <= rxd_sync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_idx <= 3'h0;
      rx_shifter <= 8'h00;
      rx_opt <= 1'b0;
    end else if (!rx_enable) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 4'h0;
    end else begin
      if (tick16) begin
        rx_cnt <= rx_cnt + 4'h1;
      end
      case (rx_state)
        RX_IDLE: begin
          if (start_seen) begin
            rx_state <= RX_START;
            rx_cnt <= 4'h0;
            rx_idx <= 3'h0;
          end
        end
        RX_START: begin
          if (rx_sample & rxd_sync) begin
            rx_state <= RX_IDLE;
          end else if (rx_bit_end) begin
            rx_state <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_shifter <= {rxd_sync, rx_shifter[7:1]};
          end
          if (rx_bit_end) begin
            if (rx_idx == last_bit) begin
              rx_state <= opt_on ? RX_OPT : RX_STOP;
            end else begin
              rx_idx <= rx_idx + 3'h1;
            end
          end
        end
        RX_OPT: begin
          if (rx_sample) begin
            rx_opt <= rxd_sync;
          end
          if (rx_bit_end) begin
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          // second stop bit is not checked; idle wait covers it
          if (rx_done) begin
            rx_state <= RX_IDLE;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_holding <= 8'h00;
      id_marker_bit <= 1'b0;
    end else if (rx_store) begin
      rx_holding <= rx_char;
      if (frame_cfg.multiproc_format) begin
        id_marker_bit <= rx_opt;
      end
    end
  end

  wire full_set = rx_store & ~stop_bad & ~par_bad;
  wire frame_set = rx_done & stop_bad;
  wire parity_set = rx_done & par_bad;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_full_flag <= 1'b0;
      rx_faults <= '0;
    end else begin
      rx_full_flag <= sticky(rx_full_flag, full_set, rx_full_clr);
      rx_faults.overrun_fault <= sticky(rx_faults.overrun_fault, overrun, rx_fault_clr.overrun_fault);
      rx_faults.frame_fault <= sticky(rx_faults.frame_fault, frame_set, rx_fault_clr.frame_fault);
      rx_faults.parity_fault <= sticky(rx_faults.parity_fault, parity_set, rx_fault_clr.parity_fault);
    end
  end

  // requests
  assign rx_fault_req = any_fault & rx_irq_en;
  assign rx_full_req = rx_full_flag & rx_irq_en;
  assign tx_empty_req = tx_empty_flag & tx_empty_irq_en & tx_enable;
  assign tx_done_req = tx_done_flag & tx_done_irq_en;

endmodule // asc_transceiver

// ---- rtl/asc_pkg.sv ----
package asc_pkg;

  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] LAST_SLOT = 4'hf;
  localparam logic [2:0] LAST_BIT_EIGHT = 3'h7;
  localparam logic [2:0] LAST_BIT_SEVEN = 3'h6;
  localparam logic [7:0] SEVEN_BIT_MASK = 8'h7f;
  localparam logic [7:0] BAUD_DIVISOR_RESET = 8'hff;
  localparam logic [5:0] PRESCALE_DIV1 = 6'h00;
  localparam logic [5:0] PRESCALE_DIV4 = 6'h03;
  localparam logic [5:0] PRESCALE_DIV16 = 6'h0f;
  localparam logic [5:0] PRESCALE_DIV64 = 6'h3f;
  localparam int unsigned TX_BUF_WIDTH = 8;
  localparam int unsigned TX_BUF_DEPTH = 2;

  typedef struct packed {
    logic seven_bit_sel;
    logic parity_on;
    logic odd_parity_sel;
    logic stop_two;
    logic multiproc_format;
    logic prescale_sel_hi;
    logic prescale_sel_lo;
  } asc_frame_cfg_type;

  typedef struct packed {
    logic overrun_fault;
    logic frame_fault;
    logic parity_fault;
  } asc_rx_fault_type;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_OPT, TX_STOP
  } asc_tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_OPT, RX_STOP
  } asc_rx_state_type;

endpackage

// ---- rtl/asc_baud_gen.sv ----
`timescale 1ns/1ps
module asc_baud_gen
  import asc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // rate setting
  input wire logic [1:0] prescale_sel,
  input wire logic [7:0] baud_divisor,
  // sixteen times bit rate
  output logic tick16
);

  function automatic logic [5:0] prescale_limit(input logic [1:0] sel);
    case (sel)
      2'h0: prescale_limit = PRESCALE_DIV1;
      2'h1: prescale_limit = PRESCALE_DIV4;
      2'h2: prescale_limit = PRESCALE_DIV16;
      default: prescale_limit = PRESCALE_DIV64;
    endcase
  endfunction

  logic [5:0] pre_cnt;
  logic [7:0] div_cnt;
  logic half;

  // bit rate = clock / (32 * 4^n * (divisor + 1)), so the 16x tick is a further /2
  wire pre_tick = (pre_cnt >= prescale_limit(prescale_sel));
  wire div_wrap = pre_tick & (div_cnt >= baud_divisor);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pre_cnt <= 6'h00;
      div_cnt <= 8'h00;
      half <= 1'b0;
      tick16 <= 1'b0;
    end else begin
      pre_cnt <= pre_tick ? 6'h00 : pre_cnt + 6'h01;
      if (pre_tick) begin
        div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
      end
      if (div_wrap) begin
        half <= ~half;
      end
      tick16 <= div_wrap & half;
    end
  end

endmodule // asc_baud_gen

// ---- rtl/asc_pair_buffer.sv ----
`timescale 1ns/1ps
module asc_pair_buffer
  import asc_pkg::*;
#(
  parameter int unsigned WIDTH = TX_BUF_WIDTH,
  parameter int unsigned DEPTH = TX_BUF_DEPTH
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (count < (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule // asc_pair_buffer

// ---- dv/asc_transceiver_checker.sv ----
`timescale 1ns/1ps
module asc_transceiver_checker
  import asc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // controls
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_empty_irq_en,
  input wire logic rx_irq_en,
  input wire logic tx_done_irq_en,
  input wire logic rx_full_clr,
  input wire asc_rx_fault_type rx_fault_clr,
  // status, requests, line
  input wire logic tx_empty_flag,
  input wire logic tx_done_flag,
  input wire logic rx_full_flag,
  input wire asc_rx_fault_type rx_faults,
  input wire logic [7:0] rx_holding,
  input wire logic rx_fault_req,
  input wire logic rx_full_req,
  input wire logic tx_empty_req,
  input wire logic tx_done_req,
  input wire logic txd_pin
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  property p_reset_state;
    $rose(resetn) |-> txd_pin && tx_empty_flag && tx_done_flag && !rx_full_flag && rx_faults == 3'h0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state");
  property p_rx_reqs;
    rx_fault_req == (rx_irq_en && rx_faults != 3'h0) && rx_full_req == (rx_irq_en && rx_full_flag);
  endproperty
  a_rx_reqs: assert property (p_rx_reqs) else $error("rx requests");
  property p_tx_reqs;
    tx_empty_req == (tx_empty_irq_en && tx_enable && tx_empty_flag) && tx_done_req == (tx_done_irq_en && tx_done_flag);
  endproperty
  a_tx_reqs: assert property (p_tx_reqs) else $error("tx requests");
  property p_tx_off;
    !tx_enable |=> tx_empty_flag && tx_done_flag && txd_pin;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx disable");
  property p_rx_off;
    !rx_enable ##1 (!rx_enable && !rx_full_clr && rx_fault_clr == 3'h0)
      |=> $stable(rx_holding) && $stable(rx_faults) && $stable(rx_full_flag);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx disable");
  property p_load_start;
    tx_enable && $past(tx_enable) && $rose(tx_empty_flag) |-> !txd_pin;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load start");
  // bound fits the longest frame at the fastest rate only
  property p_handover;
    $fell(tx_empty_flag) |-> ##[1:400] tx_empty_flag;
  endproperty
  a_handover: assert property (p_handover) else $error("handover");
  property p_fault_blocks;
    rx_faults != 3'h0 |=> !$rose(rx_full_flag);
  endproperty
  a_fault_blocks: assert property (p_fault_blocks) else $error("fault block");
  property p_overrun;
    $rose(rx_faults.overrun_fault) |-> $stable(rx_holding) && rx_full_flag;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun");
  property p_full_clean;
    $rose(rx_full_flag) |-> rx_faults == 3'h0;
  endproperty
  a_full_clean: assert property (p_full_clean) else $error("full set");
endmodule // asc_transceiver_checker

bind asc_transceiver asc_transceiver_checker chk_u (
  .sys_clk(sys_clk), .resetn(resetn), .tx_enable(tx_enable), .rx_enable(rx_enable),
  .tx_empty_irq_en(tx_empty_irq_en), .rx_irq_en(rx_irq_en), .tx_done_irq_en(tx_done_irq_en),
  .rx_full_clr(rx_full_clr), .rx_fault_clr(rx_fault_clr), .tx_empty_flag(tx_empty_flag),
  .tx_done_flag(tx_done_flag), .rx_full_flag(rx_full_flag), .rx_faults(rx_faults), .rx_holding(rx_holding),
  .rx_fault_req(rx_fault_req), .rx_full_req(rx_full_req), .tx_empty_req(tx_empty_req),
  .tx_done_req(tx_done_req), .txd_pin(txd_pin));

// ---- dv/asc_remote_node.sv ----
`timescale 1ns/1ps
module asc_remote_node (
  // clock
  input wire logic sys_clk,
  // serial line
  input wire logic txd_pin,
  output logic rxd_pin
);
  // bit cell at divisor 0, prescale 1
  localparam int BIT = 32;
  logic [11:0] got = 12'h0;
  initial rxd_pin = 1'b1;
  // cells lsb first, then back to marking
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_pin = b[i];
      repeat (BIT) @(posedge sys_clk);
      #1;
    end
    rxd_pin = 1'b1;
  endtask
  // low pulse far shorter than half a cell, must not start a frame
  task automatic glitch(input int c);
    rxd_pin = 1'b0;
    repeat (c) @(posedge sys_clk);
    #1;
    rxd_pin = 1'b1;
  endtask
  // ends on the last centre so a chained start is not missed
  task automatic grab(input int n, output logic ok);
    int k;
    k = 0;
    got = 12'h0;
    while (txd_pin !== 1'b0 && k < 2000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    ok = (k < 2000);
    for (int i = 0; i < n; i++) begin
      repeat (i == 0 ? BIT / 2 : BIT) @(posedge sys_clk);
      #1;
      got[i] = txd_pin;
    end
  endtask
endmodule // asc_remote_node

// ---- dv/test_async_serial_transceiver.sv ----
`timescale 1ns/1ps
module test_async_serial_transceiver;
  import asc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  asc_frame_cfg_type cfg = '0;
  logic tx_enable = 1'b0, rx_enable = 1'b0, irq_en = 1'b0, id_marker_tx = 1'b0;
  logic tx_wr_valid = 1'b0, rx_full_clr = 1'b0;
  logic [7:0] tx_wr_data = 8'h00;
  asc_rx_fault_type rx_fault_clr = '0;
  logic tx_wr_ready, tx_empty_flag, tx_done_flag, rx_full_flag, id_marker_bit, txd_pin, rxd_pin, ok;
  logic rx_fault_req, rx_full_req, tx_empty_req, tx_done_req;
  asc_rx_fault_type rx_faults;
  logic [7:0] rx_holding;
  logic [11:0] fb;
  int mismatches = 0, n_checks = 0, n;
  always #5 sys_clk = ~sys_clk;

  asc_transceiver dut_u (.sys_clk(sys_clk), .resetn(resetn), .frame_cfg(cfg), .baud_divisor(8'h00),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_empty_irq_en(irq_en), .rx_irq_en(irq_en),
    .tx_done_irq_en(irq_en), .id_marker_tx(id_marker_tx), .tx_wr_valid(tx_wr_valid),
    .tx_wr_data(tx_wr_data), .tx_wr_ready(tx_wr_ready), .tx_empty_flag(tx_empty_flag),
    .tx_done_flag(tx_done_flag), .rx_full_flag(rx_full_flag), .rx_faults(rx_faults),
    .rx_holding(rx_holding), .id_marker_bit(id_marker_bit), .rx_full_clr(rx_full_clr),
    .rx_fault_clr(rx_fault_clr), .rx_fault_req(rx_fault_req), .rx_full_req(rx_full_req),
    .tx_empty_req(tx_empty_req), .tx_done_req(tx_done_req), .rxd_pin(rxd_pin), .txd_pin(txd_pin));
  asc_remote_node far_u (.sys_clk(sys_clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic rxs(input logic [11:0] exp);
    chk("rx state", exp, {rx_full_flag, rx_faults, rx_holding});
  endtask
  // expected line cells for the present format; returns the cell count
  function automatic int mk(input logic [7:0] d, input logic mv, output logic [11:0] b);
    int i;
    logic [7:0] m;
    logic has;
    m = cfg.seven_bit_sel ? (d & SEVEN_BIT_MASK) : d;
    has = cfg.multiproc_format | cfg.parity_on;
    b = {3'h7, m, 1'b0};
    i = cfg.seven_bit_sel ? 8 : 9;
    b[i] = cfg.multiproc_format ? mv : (has ? (^m ^ cfg.odd_parity_sel) : 1'b1);
    i = i + 32'(has);
    b[i] = 1'b1;
    b[i + 1] = 1'b1;
    return i + 1 + 32'(cfg.stop_two);
  endfunction
  task automatic put(input logic [7:0] d);
    int k;
    k = 0;
    while (tx_wr_ready !== 1'b1 && k < 2000) begin
      cyc(1);
      k++;
    end
    if (k == 2000) begin
      mismatches++;
      close_out();
    end
    tx_wr_data = d;
    tx_wr_valid = 1'b1;
    cyc(1);
    tx_wr_valid = 1'b0;
    cyc(1);
  endtask
  task automatic see(input logic [11:0] e, input int k);
    far_u.grab(k, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      close_out();
    end
    chk("tx frame", e & ((12'h1 << k) - 12'h1), far_u.got);
  endtask
  task automatic clr(input logic full, input asc_rx_fault_type fl);
    rx_full_clr = full;
    rx_fault_clr = fl;
    cyc(1);
    rx_full_clr = 1'b0;
    rx_fault_clr = 3'h0;
  endtask
  // format changes only with both directions off, then a bit time and a quarter idle
  task automatic fmt(input logic [3:0] f);
    tx_enable = 1'b0;
    rx_enable = 1'b0;
    cyc(1);
    cfg = '{f[0], f[1], f[0] ^ f[2], f[2], f[3], 1'b0, 1'b0};
    cyc(40);
    tx_enable = 1'b1;
    rx_enable = 1'b1;
  endtask
  task automatic rxf(input logic [7:0] d, input logic [11:0] flip);
    n = mk(d, 1'b0, fb);
    far_u.send(fb ^ flip, n);
    cyc(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mv);
    logic [11:0] tf;
    int k;
    id_marker_tx = mv;
    k = mk(d, mv, tf);
    n = mk(~d, mv, fb);
    fork
      put(d);
      see(tf, k);
      far_u.send(fb, n);
    join
    cyc(4);
    rxs({4'h8, cfg.seven_bit_sel ? (~d & SEVEN_BIT_MASK) : ~d});
    if (cfg.multiproc_format)
      chk("id bit", {11'h0, mv}, {11'h0, id_marker_bit});
    clr(1'b1, 3'h0);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    chk("reset", 12'h0e1, {4'h0, txd_pin, tx_empty_flag, tx_done_flag, rx_full_flag, rx_faults, tx_wr_ready});
    rxs(12'h000);
    irq_en = 1'b1;
    for (int f = 0; f < 16; f++) begin
      fmt(4'(f));
      xfer(8'h5a ^ 8'(f * 37), f[1]);
    end
    fmt(4'h2);
    rxf(8'h3c, 12'h200);
    rxs(12'h13c);
    chk("fault req", 12'h1, {11'h0, rx_fault_req});
    rxf(8'h99, 12'h000);
    rxs(12'h13c);
    clr(1'b0, 3'h7);
    rxf(8'h81, 12'h400);
    rxs(12'h281);
    clr(1'b0, 3'h7);
    far_u.glitch(4);
    cyc(400);
    rxs(12'h081);
    rxf(8'h11, 12'h000);
    rxs(12'h811);
    rxf(8'h22, 12'h000);
    rxs(12'hc11);
    rx_enable = 1'b0;
    cyc(5);
    rxs(12'hc11);
    clr(1'b1, 3'h7);
    tx_enable = 1'b0;
    put(8'hc3);
    put(8'h3c);
    chk("ready", 12'h0, {11'h0, tx_wr_ready});
    tx_enable = 1'b1;
    n = mk(8'hc3, 1'b0, fb);
    see(fb, n);
    n = mk(8'h3c, 1'b0, fb);
    see(fb, n);
    cyc(40);
    chk("done", 12'h1, {11'h0, tx_done_flag});
    put(8'hf0);
    cyc(60);
    tx_enable = 1'b0;
    cyc(2);
    chk("tx off", 12'h7, {9'h0, tx_empty_flag, tx_done_flag, txd_pin});
    close_out();
  end
endmodule // test_async_serial_transceiver
